// file: hw/i2cm_cfg.svh
// Purpose: Offsets, field positions and reset values of the I2C master port.
// Assumes: Word addressing; each offset selects one 32-bit register.
// Notes:   Period counts are in system clock cycles.
`ifndef I2CM_CFG_SVH
`define I2CM_CFG_SVH

// ------------------------------------------------------------
// Register word offsets
// ------------------------------------------------------------
`define I2CM_OFF_CMD      4'h0
`define I2CM_OFF_RX       4'h1
`define I2CM_OFF_CTRL     4'h2
`define I2CM_OFF_IEN      4'h3
`define I2CM_OFF_IPEND    4'h4
`define I2CM_OFF_STATE    4'h5
`define I2CM_OFF_CMD_FILL 4'h6
`define I2CM_OFF_RX_FILL  4'h7
`define I2CM_OFF_LOW      4'h8
`define I2CM_OFF_HIGH     4'h9
`define I2CM_OFF_HOLD     4'ha

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define I2CM_CTRL_EN      0
`define I2CM_CTRL_TXT     2
`define I2CM_CTRL_RXT     4
`define I2CM_IP_TXR       0
`define I2CM_IP_RXR       1
`define I2CM_IP_NACK      2
`define I2CM_IP_ARB       3
`define I2CM_IP_OVR       4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define I2CM_CTRL_RST     6'h00
`define I2CM_IEN_RST      5'h00
`define I2CM_LOW_RST      16'h03e8
`define I2CM_HIGH_RST     16'h03e8
`define I2CM_HOLD_RST     16'h001e

`endif

// file: hw/i2cm_pkg.sv
// Purpose: Types shared by the I2C master port.
// Assumes: Command words are ten bits wide.
// Notes:   State codes are written out in binary.
`default_nettype none

package i2cm_pkg;

	// Line engine states.
	typedef enum logic [3:0]
	{
		ST_IDLE      = 4'b0000,
		ST_HOLD      = 4'b0001,
		ST_RS_LOW    = 4'b0010,
		ST_RS_HIGH   = 4'b0011,
		ST_START     = 4'b0100,
		ST_BIT_LOW   = 4'b0101,
		ST_BIT_HIGH  = 4'b0110,
		ST_STOP_LOW  = 4'b0111,
		ST_STOP_HIGH = 4'b1000,
		ST_STOP_REL  = 4'b1001
	} i2cm_state_t;

	// One command word as queued.
	typedef struct packed
	{
		logic       repeat_start_request;
		logic       stop_request;
		logic [7:0] ad;
	} i2cm_cmd_t;

	// Sticky event flags.
	typedef struct packed
	{
		logic over;
		logic arb;
		logic nack;
	} i2cm_event_t;

endpackage

`default_nettype wire

// file: hw/i2cm_port.sv
// Purpose: I2C master register port, command/receive queues and line engine.
// Assumes: Reset is released synchronously by the surrounding logic.
// Notes:   STREAM selects streaming ports instead of register queue access.
//
// What this block does
// RULE_01: Streaming source asserts command valid only with a valid word.
// RULE_02: Command ready high when a word fits; transfer on valid and ready.
// RULE_03: SCL enable high pulls clock low; low releases it.
// RULE_04: SDA enable high pulls data low; low releases it.
// RULE_05: Line levels are read back through separate inputs.
// RULE_06: One active-high level interrupt output.
// RULE_07: Each address offset is one 32-bit word.
// RULE_08: Eleven word offsets decoded in table order, 0x0 through 0xa.
// RULE_09: Bit 9 set makes a repeated START before the byte.
// RULE_10: Bit 8 set makes a STOP after the byte.
// RULE_11: Address phase sends command bits 7:1 as slave address.
// RULE_12: Address phase sends bit 0 as direction, 1 meaning read.
// RULE_13: Transmit data phase sends bits 7:1 as data bits 7:1.
// RULE_14: Transmit data phase sends bit 0 as data bit 0.
// RULE_15: Receive data phase ignores bits 7:0; only start and stop act.
// RULE_16: Command register write-only; receive register returns byte, rest zero.
// RULE_17: Register access mode leaves streaming ports unused.
// RULE_18: Streaming command words are full ten bits, pushed to the queue.
// RULE_19: Streaming receive output presents bytes with a valid flag.
// RULE_20: Active-low reset asserts asynchronously; release synchronised outside.
// RULE_21: Address input is a four-bit word address.
// RULE_22: Command writes push one entry; receive reads pop one byte.
`timescale 1ns/1ps
`default_nettype none
`include "i2cm_cfg.svh"

module i2cm_port
	import i2cm_pkg::*;
#(
	parameter bit STREAM = 1'b0,
	parameter int DEPTH  = 4,
	parameter int CNT_W  = 16
)
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_sys_rst_n,
	input  wire logic [3:0]  i_addr,
	input  wire logic        i_read,
	input  wire logic        i_write,
	input  wire logic [31:0] i_writedata,
	output var  logic [31:0] o_readdata,
	output var  logic [7:0]  o_src_data,
	output var  logic        o_src_valid,
	input  wire logic        i_src_ready,
	input  wire i2cm_cmd_t   i_snk_data,
	input  wire logic        i_snk_valid,
	output var  logic        o_snk_ready,
	output var  logic        o_scl_oe,
	output var  logic        o_sda_oe,
	input  wire logic        i_scl_in,
	input  wire logic        i_sda_in,
	output var  logic        o_intr
);

	localparam int AW = $clog2(DEPTH);
	localparam int LW = AW + 1;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	i2cm_cmd_t          cmd_mem [DEPTH];
	logic [7:0]         rx_mem  [DEPTH];
	logic [AW-1:0]      cmd_wp_r, cmd_rp_r, rx_wp_r, rx_rp_r;
	logic [LW-1:0]      cmd_cnt_r, rx_cnt_r, cmd_cnt_nxt;
	logic               cmd_push, cmd_push_ok, cmd_pop;
	logic               rx_push, rx_push_ok, rx_pop;
	logic [5:0]         ctrl_r;
	logic [4:0]         ien_r;
	logic [CNT_W-1:0]   low_r, high_r, hold_r, tick_r;
	i2cm_event_t        ev_r, ev_set, ev_clr;
	logic [4:0]         pend;
	logic [31:0]        rd_nxt;
	logic               scl_m_r, scl_s_r, sda_m_r, sda_s_r;
	i2cm_state_t        state_r;
	i2cm_cmd_t          cur_r;
	logic [7:0]         sh_r;
	logic [3:0]         bit_r;
	logic               addr_ph_r, rd_dir_r, tx_byte;
	logic               sel_cmd, sel_rx;
	logic [7:0]         sb1_r;
	logic               sbv1_r;

	// Threshold levels for the ready indications.
	function automatic logic [LW-1:0] thr(input logic [1:0] c,
		input logic rx);
		case (c)
			2'h0:    thr = rx ? LW'(1) : LW'(0);
			2'h1:    thr = LW'(DEPTH / 4);
			2'h2:    thr = LW'(DEPTH / 2);
			default: thr = rx ? LW'(DEPTH) : LW'(DEPTH - 1);
		endcase
	endfunction

	// ------------------------------------------------------------
	// Line input synchronisers
	// ------------------------------------------------------------
	// Two flops per line before the engine looks at the level.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)
		begin
			scl_m_r <= 1'b1;
			scl_s_r <= 1'b1;
			sda_m_r <= 1'b1;
			sda_s_r <= 1'b1;
		end
		else
		begin
			scl_m_r <= i_scl_in;   // [RULE_05]
			scl_s_r <= scl_m_r;
			sda_m_r <= i_sda_in;   // [RULE_05]
			sda_s_r <= sda_m_r;
		end
	end

	// ------------------------------------------------------------
	// Command queue
	// ------------------------------------------------------------
	// Word select, pushes from registers or stream, and the level update.
	assign sel_cmd  = i_write && (i_addr == `I2CM_OFF_CMD);   // [RULE_07]
	assign sel_rx   = i_read && (i_addr == `I2CM_OFF_RX);     // [RULE_21]
	assign cmd_push = STREAM ? (i_snk_valid && o_snk_ready)    // [RULE_02]
		: sel_cmd;                                         // [RULE_17]
	assign cmd_push_ok = cmd_push && (cmd_cnt_r != LW'(DEPTH)); // [RULE_22]
	assign cmd_pop  = ((state_r == ST_IDLE) || (state_r == ST_HOLD))
		&& ctrl_r[`I2CM_CTRL_EN] && (cmd_cnt_r != '0);
	assign cmd_cnt_nxt = cmd_cnt_r + LW'(cmd_push_ok) - LW'(cmd_pop);

	// Queue storage: streaming words carry all ten bits.
	always_ff @(posedge i_sys_clk)
	begin
		if (cmd_push_ok)
			cmd_mem[cmd_wp_r] <= STREAM ? i_snk_data              // [RULE_18]
				: i2cm_cmd_t'(i_writedata[9:0]);            // [RULE_16]
	end

	// Queue pointers, level and stream ready.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)                                     // [RULE_20]
		begin
			cmd_wp_r    <= '0;
			cmd_rp_r    <= '0;
			cmd_cnt_r   <= '0;
			o_snk_ready <= 1'b0;
		end
		else
		begin
			cmd_wp_r    <= cmd_wp_r + AW'(cmd_push_ok);
			cmd_rp_r    <= cmd_rp_r + AW'(cmd_pop);
			cmd_cnt_r   <= cmd_cnt_nxt;
			o_snk_ready <= STREAM && (cmd_cnt_nxt != LW'(DEPTH)); // [RULE_02]
		end
	end

	// ------------------------------------------------------------
	// Receive queue and stream buffer
	// ------------------------------------------------------------
	// A full queue drops the byte and flags an overrun.
	assign rx_push_ok = rx_push && (rx_cnt_r != LW'(DEPTH));
	assign rx_pop = (rx_cnt_r != '0) && (STREAM ? !sbv1_r     // [RULE_19]
		: sel_rx);                                         // [RULE_22]

	// Receive storage.
	always_ff @(posedge i_sys_clk)
	begin
		if (rx_push_ok)
			rx_mem[rx_wp_r] <= sh_r;
	end

	// Receive pointers and level.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)
		begin
			rx_wp_r  <= '0;
			rx_rp_r  <= '0;
			rx_cnt_r <= '0;
		end
		else
		begin
			rx_wp_r  <= rx_wp_r + AW'(rx_push_ok);
			rx_rp_r  <= rx_rp_r + AW'(rx_pop);
			rx_cnt_r <= rx_cnt_r + LW'(rx_push_ok) - LW'(rx_pop);
		end
	end

	// Two-entry buffer: head drives the output, second entry absorbs a stall.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)
		begin
			o_src_valid <= 1'b0;
			sbv1_r      <= 1'b0;
		end
		else if (o_src_valid && i_src_ready)
		begin
			o_src_valid <= sbv1_r || (STREAM && rx_pop);    // [RULE_19]
			sbv1_r      <= 1'b0;
		end
		else if (STREAM && rx_pop)
		begin
			if (o_src_valid)
				sbv1_r <= 1'b1;
			o_src_valid <= 1'b1;
		end
	end

	// Buffer data follows the same moves as the valid flags.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)
		begin
			o_src_data <= 8'h00;
			sb1_r      <= 8'h00;
		end
		else if (o_src_valid && i_src_ready)
			o_src_data <= sbv1_r ? sb1_r : rx_mem[rx_rp_r];
		else if (STREAM && rx_pop)
		begin
			if (o_src_valid)
				sb1_r <= rx_mem[rx_rp_r];
			else
				o_src_data <= rx_mem[rx_rp_r];
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Software-written control and period registers.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)
		begin
			ctrl_r <= `I2CM_CTRL_RST;
			ien_r  <= `I2CM_IEN_RST;
			low_r  <= CNT_W'(`I2CM_LOW_RST);
			high_r <= CNT_W'(`I2CM_HIGH_RST);
			hold_r <= CNT_W'(`I2CM_HOLD_RST);
		end
		else if (i_write)
		begin
			case (i_addr)                                      // [RULE_08]
				`I2CM_OFF_CTRL: ctrl_r <= i_writedata[5:0];
				`I2CM_OFF_IEN:  ien_r  <= i_writedata[4:0];
				`I2CM_OFF_LOW:  low_r  <= i_writedata[CNT_W-1:0];
				`I2CM_OFF_HIGH: high_r <= i_writedata[CNT_W-1:0];
				`I2CM_OFF_HOLD: hold_r <= i_writedata[CNT_W-1:0];
				default:        ;
			endcase
		end
	end

	// Sticky events: write one to clear, a new event wins over the clear.
	assign ev_clr = (i_write && (i_addr == `I2CM_OFF_IPEND)) ?
		i2cm_event_t'(i_writedata[4:2]) : '0;
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)
			ev_r <= '0;
		else
			ev_r <= (ev_r & ~ev_clr) | ev_set;
	end

	// Pending view: sticky events plus live level indications.
	assign pend = {ev_r,
		rx_cnt_r >= thr(ctrl_r[`I2CM_CTRL_RXT+:2], 1'b1),
		cmd_cnt_r <= thr(ctrl_r[`I2CM_CTRL_TXT+:2], 1'b0)};

	// Read multiplexer; unmapped and write-only words read zero.
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		case (i_addr)                                          // [RULE_08]
			`I2CM_OFF_RX:       rd_nxt[7:0] = rx_mem[rx_rp_r]; // [RULE_16]
			`I2CM_OFF_CTRL:     rd_nxt[5:0] = ctrl_r;
			`I2CM_OFF_IEN:      rd_nxt[4:0] = ien_r;
			`I2CM_OFF_IPEND:    rd_nxt[4:0] = pend;
			`I2CM_OFF_STATE:    rd_nxt[0]   = (state_r != ST_IDLE);
			`I2CM_OFF_CMD_FILL: rd_nxt[LW-1:0] = cmd_cnt_r;
			`I2CM_OFF_RX_FILL:  rd_nxt[LW-1:0] = rx_cnt_r;
			`I2CM_OFF_LOW:      rd_nxt[CNT_W-1:0] = low_r;
			`I2CM_OFF_HIGH:     rd_nxt[CNT_W-1:0] = high_r;
			`I2CM_OFF_HOLD:     rd_nxt[CNT_W-1:0] = hold_r;
			default:            rd_nxt = 32'h0000_0000;
		endcase
		if ((i_addr == `I2CM_OFF_RX) && (STREAM || (rx_cnt_r == '0)))
			rd_nxt = 32'h0000_0000;
	end

	// Read data register and the interrupt level.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)
		begin
			o_readdata <= 32'h0000_0000;
			o_intr     <= 1'b0;
		end
		else
		begin
			if (i_read)
				o_readdata <= rd_nxt;
			o_intr <= |(pend & ien_r);                         // [RULE_06]
		end
	end

	// ------------------------------------------------------------
	// Line engine
	// ------------------------------------------------------------
	// Address bytes and write data are sent; read data sends all ones.
	assign tx_byte = addr_ph_r || !rd_dir_r;
	always_comb
	begin
		ev_set  = '0;
		rx_push = 1'b0;
		if ((state_r == ST_BIT_HIGH) && scl_s_r && (tick_r == high_r))
		begin
			if ((bit_r != 4'h8) && tx_byte && !o_sda_oe && !sda_s_r)
				ev_set.arb = 1'b1;
			else if ((bit_r == 4'h8) && tx_byte && sda_s_r)
				ev_set.nack = 1'b1;
			else if ((bit_r == 4'h8) && !tx_byte)
				rx_push = 1'b1;
		end
		ev_set.over = rx_push && !rx_push_ok;
	end

	// Bit sequencing with low, high and hold periods from the registers.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
	begin
		if (!i_sys_rst_n)
		begin
			state_r   <= ST_IDLE;
			tick_r    <= '0;
			bit_r     <= 4'h0;
			sh_r      <= 8'h00;
			cur_r     <= '0;
			addr_ph_r <= 1'b0;
			rd_dir_r  <= 1'b0;
			o_scl_oe  <= 1'b0;
			o_sda_oe  <= 1'b0;
		end
		else
		begin
			tick_r <= tick_r + CNT_W'(1);
			case (state_r)
				ST_IDLE, ST_HOLD:
				begin
					tick_r <= '0;
					if (cmd_pop)
					begin
						cur_r <= cmd_mem[cmd_rp_r];
						bit_r <= 4'h0;
						sh_r  <= (tx_byte || cmd_mem[cmd_rp_r].repeat_start_request)
							? cmd_mem[cmd_rp_r].ad : 8'hff;   // [RULE_13] [RULE_15]
						if (state_r == ST_IDLE)
						begin
							o_sda_oe <= 1'b1;                     // [RULE_04]
							state_r  <= ST_START;
						end
						else if (cmd_mem[cmd_rp_r].repeat_start_request)
							state_r <= ST_RS_LOW;                 // [RULE_09]
						else
							state_r <= ST_BIT_LOW;
					end
				end
				ST_RS_LOW:
				begin
					if (tick_r == hold_r)
						o_sda_oe <= 1'b0;
					if (tick_r == low_r)
					begin
						o_scl_oe <= 1'b0;                         // [RULE_03]
						tick_r   <= '0;
						state_r  <= ST_RS_HIGH;
					end
				end
				ST_RS_HIGH, ST_STOP_HIGH:
				begin
					if (!scl_s_r)
						tick_r <= '0;
					else if (tick_r == high_r)
					begin
						o_sda_oe <= (state_r == ST_RS_HIGH);  // [RULE_09] [RULE_10]
						tick_r   <= '0;
						state_r  <= (state_r == ST_RS_HIGH) ? ST_START
							: ST_STOP_REL;
					end
				end
				ST_START:
				begin
					if (tick_r == high_r)
					begin
						o_scl_oe  <= 1'b1;                        // [RULE_03]
						sh_r      <= cur_r.ad;                    // [RULE_11]
						rd_dir_r  <= cur_r.ad[0];                 // [RULE_12]
						addr_ph_r <= 1'b1;
						tick_r    <= '0;
						state_r   <= ST_BIT_LOW;
					end
				end
				ST_BIT_LOW:
				begin
					if (tick_r == hold_r)
						o_sda_oe <= (bit_r == 4'h8)
							? (!tx_byte && !cur_r.stop_request)
							: !sh_r[7];                         // [RULE_14]
					if (tick_r == low_r)
					begin
						o_scl_oe <= 1'b0;
						tick_r   <= '0;
						state_r  <= ST_BIT_HIGH;
					end
				end
				ST_BIT_HIGH:
				begin
					if (!scl_s_r)
						tick_r <= '0;
					else if (tick_r == high_r)
					begin
						tick_r   <= '0;
						o_scl_oe <= 1'b1;
						if (ev_set.arb)
						begin
							o_scl_oe <= 1'b0;
							o_sda_oe <= 1'b0;
							state_r  <= ST_IDLE;
						end
						else if (bit_r != 4'h8)
						begin
							sh_r    <= {sh_r[6:0], sda_s_r};
							bit_r   <= bit_r + 4'h1;
							state_r <= ST_BIT_LOW;
						end
						else
						begin
							addr_ph_r <= 1'b0;
							state_r   <= (ev_set.nack || cur_r.stop_request)
								? ST_STOP_LOW : ST_HOLD;          // [RULE_10]
						end
					end
				end
				ST_STOP_LOW:
				begin
					if (tick_r == hold_r)
						o_sda_oe <= 1'b1;
					if (tick_r == low_r)
					begin
						o_scl_oe <= 1'b0;
						tick_r   <= '0;
						state_r  <= ST_STOP_HIGH;
					end
				end
				ST_STOP_REL:
				begin
					if (tick_r == high_r)
						state_r <= ST_IDLE;
				end
				default:
				begin
					o_scl_oe <= 1'b0;
					o_sda_oe <= 1'b0;
					state_r  <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// file: sim/i2cm_port_checker.sv
// Purpose: Concurrent checks on the pins of the I2C master port.
// Assumes: One clock domain with an active-low reset.
// Notes:   Bound to every instance of the port.
`timescale 1ns/1ps
`default_nettype none

module i2cm_port_checker
(
	input wire logic        i_sys_clk,
	input wire logic        i_sys_rst_n,
	input wire logic [3:0]  i_addr,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [31:0] o_readdata,
	input wire logic [7:0]  o_src_data,
	input wire logic        o_src_valid,
	input wire logic        i_src_ready,
	input wire logic        i_snk_valid,
	input wire logic        o_snk_ready,
	input wire logic        o_scl_oe,
	input wire logic        o_sda_oe,
	input wire logic        o_intr
);
	logic mask_seen_r;
	logic rst_seen_r;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_sys_rst_n);

	// -----------------------------------------------------------------
	// Helper state and sequences
	// -----------------------------------------------------------------
	// Remembers whether any interrupt source was ever unmasked.
	always_ff @(posedge i_sys_clk or negedge i_sys_rst_n)
		if (!i_sys_rst_n)
			mask_seen_r <= 1'b0;
		else if (i_write && i_addr == 4'h3 && |i_writedata[4:0])
			mask_seen_r <= 1'b1;

	// Marks edges that follow an edge already in reset; the very first
	// edge sees outputs that no reset branch has reached yet.
	always_ff @(posedge i_sys_clk)
		rst_seen_r <= !i_sys_rst_n;

	// A start: data pulled low while the clock line is released.
	sequence s_start;
		!o_scl_oe && $rose(o_sda_oe);
	endsequence

	// A stalled receive byte.
	sequence s_stall;
		o_src_valid && !i_src_ready;
	endsequence

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	AST_RST_QUIET: assert property (disable iff (1'b0)
		!i_sys_rst_n && rst_seen_r |->
		!o_scl_oe && !o_sda_oe && !o_src_valid && !o_intr)
		else $error("outputs active in reset");
	AST_UNMAPPED_ZERO: assert property (
		i_read && i_addr > 4'ha |=> o_readdata == 32'h0)
		else $error("unmapped read not zero");
	AST_RX_UPPER_ZERO: assert property (
		i_read && i_addr == 4'h1 |=> o_readdata[31:8] == 24'h0)
		else $error("receive word upper bits set");
	AST_READ_STANDS: assert property (
		!i_read |=> $stable(o_readdata))
		else $error("read data moved without a read");
	AST_READY_FALL: assert property (
		$fell(o_snk_ready) |-> $past(i_snk_valid))
		else $error("command ready fell without a transfer");
	AST_SRC_HOLD: assert property (
		s_stall |=> o_src_valid && $stable(o_src_data))
		else $error("stalled receive byte lost");
	AST_INTR_MASKED: assert property (
		!mask_seen_r |-> !o_intr)
		else $error("interrupt with all sources masked");
	AST_SCL_LOW_MIN: assert property (
		$rose(o_scl_oe) |-> o_scl_oe[*2])
		else $error("clock low phase too short");
	AST_START_HIGH: assert property (
		s_start |=> !o_scl_oe)
		else $error("clock pulled right after start");
endmodule

bind i2cm_port i2cm_port_checker u_i2cm_port_checker
(
	.i_sys_clk, .i_sys_rst_n, .i_addr, .i_read, .i_write, .i_writedata,
	.o_readdata, .o_src_data, .o_src_valid, .i_src_ready, .i_snk_valid,
	.o_snk_ready, .o_scl_oe, .o_sda_oe, .o_intr
);

`default_nettype wire

// file: sim/i2cm_slave_model.sv
// Purpose: Behavioural I2C slave facing the master port.
// Assumes: Both lines are open drain with pull-ups.
// Notes:   Acks every address and written byte; sends RD_BYTE on reads.
`timescale 1ns/1ps
`default_nettype none

module i2cm_slave_model
#(
	parameter logic [7:0] RD_BYTE = 8'hc3
)
(
	input  wire logic i_scl,
	input  wire logic i_sda,
	output var  logic o_sda_pull
);
	logic [7:0] rx      = 8'h00;
	logic       rd      = 1'b0;
	logic       addr_ph = 1'b0;
	logic       frame_on = 1'b0;
	int         bitn    = 0;
	int         starts  = 0;
	int         stops   = 0;
	logic [7:0] got[$];

	initial o_sda_pull = 1'b0;

	// Data falling while the clock is high opens a frame.
	always @(negedge i_sda)
		if (i_scl === 1'b1)
		begin
			starts++;
			bitn = 0;
			addr_ph = 1'b1;
			rd = 1'b0;
			frame_on = 1'b1;
		end

	// Data rising while the clock is high closes an open frame; the rise
	// out of the unknown level at power-up is no stop.
	always @(posedge i_sda)
		if (i_scl === 1'b1 && frame_on)
		begin
			stops++;
			frame_on = 1'b0;
		end

	// Shifts in one bit per clock high; a read ends when the master nacks.
	always @(posedge i_scl)
	begin
		if (bitn < 8)
			rx = {rx[6:0], i_sda};
		else if (rd && !addr_ph && i_sda)
			rd = 1'b0;
		bitn++;
	end

	// Drives acknowledge and read data only while the clock is low.
	always @(negedge i_scl)
		if (bitn == 8)
		begin
			got.push_back(rx);
			if (addr_ph)
				rd = rx[0];
			o_sda_pull = !(rd && !addr_ph);
		end
		else if (bitn == 9)
		begin
			bitn = 0;
			addr_ph = 1'b0;
			o_sda_pull = rd && !RD_BYTE[7];
		end
		else if (rd && !addr_ph)
			o_sda_pull = !RD_BYTE[7 - bitn];
endmodule

`default_nettype wire

// file: sim/i2cm_port_tb_top.sv
// Purpose: Self-checking bench for the I2C master port in streaming mode.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Bit timing counts are shortened through the registers.
`timescale 1ns/1ps
`default_nettype none

module i2cm_port_tb_top;
	import i2cm_pkg::*;
	logic        clk       = 1'b0;
	logic        rst_n     = 1'b0;
	logic [3:0]  addr      = 4'h0;
	logic        rd        = 1'b0;
	logic        wr        = 1'b0;
	logic [31:0] wdata     = 32'h0;
	logic        src_ready = 1'b0;
	logic        snk_valid = 1'b0;
	i2cm_cmd_t   snk_data  = '0;
	logic [31:0] rdata;
	logic [7:0]  src_data;
	logic        src_valid, snk_ready, scl_oe, sda_oe, intr;
	wire logic   sda_pull, scl_w, sda_w;
	int          error_cnt = 0;
	int          cmp_count = 0;
	int          cyc       = 0;
	logic [3:0]  offs[11]  = '{4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb, 4'h1,
		4'h5, 4'h6, 4'h4, 4'h7};
	logic [31:0] rstv[11]  = '{32'h0, 32'h0, 32'h3e8, 32'h3e8, 32'h1e,
		32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0};

	// Open-drain lines: released lines float to the pull-up level.
	assign scl_w = ~scl_oe;
	assign sda_w = ~(sda_oe | sda_pull);

	// Clock generator.
	always #2.5 clk = ~clk;

	i2cm_port #(.STREAM(1'b1)) u_i2cm_port
	(
		.i_sys_clk(clk), .i_sys_rst_n(rst_n), .i_addr(addr), .i_read(rd),
		.i_write(wr), .i_writedata(wdata), .o_readdata(rdata),
		.o_src_data(src_data), .o_src_valid(src_valid),
		.i_src_ready(src_ready), .i_snk_data(snk_data),
		.i_snk_valid(snk_valid), .o_snk_ready(snk_ready), .o_scl_oe(scl_oe),
		.o_sda_oe(sda_oe), .i_scl_in(scl_w), .i_sda_in(sda_w),
		.o_intr(intr)
	);

	i2cm_slave_model u_i2cm_slave_model
	(
		.i_scl(scl_w),
		.i_sda(sda_w),
		.o_sda_pull(sda_pull)
	);

	// -----------------------------------------------------------------
	// Shared tasks
	// -----------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask

	task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		d = rdata;
	endtask

	// Offers a word only once ready is seen, then holds it for one edge.
	task automatic push(input logic [9:0] w);
		int n;
		n = 0;
		@(negedge clk);
		while (snk_ready !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 2000)
			error_cnt++;
		snk_data = i2cm_cmd_t'(w);
		snk_valid = 1'b1;
		@(negedge clk);
		snk_valid = 1'b0;
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	// Reset values, interrupt level, word addressing, ignored queue writes.
	task automatic t_regs();
		logic [31:0] d;
		for (int i = 0; i < 11; i++)
		begin
			reg_rd(offs[i], d);
			chk(d, rstv[i]);
		end
		reg_wr(4'h3, 32'h1);
		@(negedge clk);
		chk({31'h0, intr}, 32'h1);
		reg_wr(4'h3, 32'h0);
		@(negedge clk);
		chk({31'h0, intr}, 32'h0);
		reg_wr(4'h8, 32'h4);
		reg_wr(4'h9, 32'h4);
		reg_wr(4'ha, 32'h2);
		reg_rd(4'h9, d);
		chk(d, 32'h4);
		reg_wr(4'h0, 32'h0a0);
		reg_rd(4'h6, d);
		chk(d, 32'h0);
	endtask

	// Fills the queue until refused, then runs write, restart and read.
	task automatic t_frames();
		logic [31:0] d;
		int          n;
		n = 0;
		push(10'h0a0);
		push(10'h05a);
		push(10'h2a1);
		push(10'h100);
		chk({31'h0, snk_ready}, 32'h0);
		reg_rd(4'h6, d);
		chk(d, 32'h4);
		reg_wr(4'h2, 32'h1);
		while (u_i2cm_slave_model.stops < 1 && n < 8000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 8000)
			error_cnt++;
		chk(u_i2cm_slave_model.got.size(), 32'h4);
		if (u_i2cm_slave_model.got.size() == 4)
		begin
			chk(u_i2cm_slave_model.got[0], 32'ha0);
			chk(u_i2cm_slave_model.got[1], 32'h5a);
			chk(u_i2cm_slave_model.got[2], 32'ha1);
			chk(u_i2cm_slave_model.got[3], 32'hc3);
		end
		chk(u_i2cm_slave_model.starts, 32'h2);
		chk(u_i2cm_slave_model.stops, 32'h1);
	endtask

	// Stalls the received byte, then takes it in one beat.
	task automatic t_stream_out();
		repeat (12) @(negedge clk);
		chk({31'h0, src_valid}, 32'h1);
		chk({24'h0, src_data}, 32'hc3);
		src_ready = 1'b1;
		@(negedge clk);
		src_ready = 1'b0;
		chk({31'h0, src_valid}, 32'h0);
	endtask

	// -----------------------------------------------------------------
	// Main sequence and watchdog
	// -----------------------------------------------------------------
	initial
	begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		t_regs();
		t_frames();
		t_stream_out();
		results();
	end

	// Cuts a hang short well beyond the expected run length.
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			results();
		end
	end
endmodule

`default_nettype wire
